// [inc/cfc_defines.svh]
/*
  constants of the fault confinement block: register offsets, field
  positions, reset values, thresholds and bit counts.
  assumes nothing; included by bare name wherever needed.
*/
`ifndef CFC_DEFINES_SVH
`define CFC_DEFINES_SVH

// register byte offsets on the plain register port
`define CFC_OFS_PAIR 4'h0
`define CFC_OFS_CTRL 4'h4
`define CFC_OFS_STAT 4'h8

// fault_counter_pair fields: receive count low byte, transmit count high byte
`define CFC_PAIR_RX_LSB 0
`define CFC_PAIR_TX_LSB 8

// control register: bit 0 enables the module
`define CFC_CTRL_EN_BIT 0
`define CFC_CTRL_RESET 16'h0000

// fault thresholds
`define CFC_WARN_LIMIT 9'h060
`define CFC_PASSIVE_LIMIT 9'h07F
`define CFC_BUSOFF_LIMIT 9'h0FF

// counter steps
`define CFC_STEP_BIG 5'h08
`define CFC_STEP_SMALL 5'h01

// bit counts
`define CFC_IDLE_RUN_BITS 4'hB
`define CFC_BUSOFF_RUNS 8'h80
`define CFC_DOM_FIRST_ACTIVE 4'hE
`define CFC_DOM_FIRST_PASSIVE 4'h8
`define CFC_DOM_REPEAT 4'h8

`endif

// [inc/cfc_pkg.sv]
/*
  types of the fault confinement block.
  does not need cfc_defines.svh; the state encodings are written inline.
*/
package cfc_pkg;

  // node states with respect to error handling
  typedef enum logic [2:0] {
    ST_SYNC = 3'b000,
    ST_ACTIVE = 3'b001,
    ST_WARNING = 3'b010,
    ST_PASSIVE = 3'b011,
    ST_BUSOFF = 3'b100
  } cfc_state_t;

  // one-cycle event pulses from the protocol engine, same clock
  typedef struct packed {
    logic is_tx;          // level: node is transmitter of the current frame
    logic bit_err_flag;   // bit error while driving a dominant error flag
    logic dom_after_flag; // first bit after own error flag was dominant
    logic other_err;      // stuff, form, crc or ack error
    logic arb_stuff;      // the other_err is a stuff error in arbitration
    logic ack_err;        // the other_err is an acknowledge error
    logic dom_in_pflag;   // dominant bit seen during own passive flag
    logic flag_done;      // own error or overload flag has ended
    logic flag_passive;   // the ended flag was a recessive error flag
    logic valid_rx;       // frame received without error
    logic valid_tx;       // frame transmitted without error
  } cfc_event_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } cfc_reg_req_t;

endpackage : cfc_pkg

// [rtl/cfc_run_counter.sv]
/*
  counts consecutive recessive bits and pulses once per full run.
  assumes bit_tick is a one-cycle pulse at each sample point and
  bus_level is already synchronised (1 = recessive).
*/
`timescale 1ns/1ns
`include "cfc_defines.svh"

module cfc_run_counter (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic bit_tick,
  input wire logic bus_level,
  output logic run_done
);

  typedef struct packed {
    logic [3:0] cnt;
    logic done;
  } cfc_run_t;

  cfc_run_t r;
  cfc_run_t next_r;

  // a dominant bit restarts the run; a full run restarts it too
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (clear) begin
      next_r.cnt = 4'h0;
    end else if (bit_tick) begin
      if (!bus_level) begin
        next_r.cnt = 4'h0;
      end else if (r.cnt == `CFC_IDLE_RUN_BITS - 4'h1) begin
        next_r.cnt = 4'h0;
        next_r.done = 1'b1;
      end else begin
        next_r.cnt = r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign run_done = r.done;

endmodule : cfc_run_counter

// [rtl/cfc_fault_confinement.sv]
/*
  fault confinement of a can node: receive and transmit fault counters,
  the five error states, error flag polarity, driver enable, recovery.
  assumes the protocol engine and bit timing logic run on CLK and
  deliver one-cycle pulses; the bus receive pin is asynchronous.
*/
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "cfc_defines.svh"

// How it works
// - after enable, wait for 11 recessive bits, then become error active.
// - a wake-up also passes through the 11-recessive-bit synchronisation.
// - error active node communicates and sends dominant error flags.
// - warning behaves as active; leave it once both counters below 96.
// - error passive when either counter exceeds 127.
// - passive node sends only recessive error flags.
// - the error that causes the passive crossing still gets a dominant flag.
// - passive falls back to warning, or to active if both are below 96, once both counters are below 128.
// - bus off when transmit counter exceeds 255.
// - bus off disables drivers and ignores all bus activity except the recessive runs it counts for recovery.
// - bus off recovers after 128 runs of 11 recessive bits, counters cleared.
// - an 8-bit receive and a 9-bit transmit counter, read together in one 16-bit register.
// - receive counter stops incrementing once its bit 7 is set.
// - receiver bit error during dominant flag adds 8 to receive counter.
// - receiver sees dominant first bit after its flag: add 8.
// - 14th dominant after active/overload flag, 8th after passive, then every 8: add 8.
// - other errors add 1 when receiving, 8 when transmitting.
// - valid reception or transmission decrements its counter, never below zero.
// - transmitter bit error during dominant flag adds 8 to transmit counter.
// - no transmit increment for stuff error during arbitration.
// - no transmit increment for ack error while passive without dominant in flag.
// - unacknowledged transmission is an error and is repeated.
module cfc_fault_confinement
  import cfc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CAN_RX,
  input wire logic BIT_TICK,
  input wire logic WAKE,
  input cfc_pkg::cfc_event_t EVENTS,
  input cfc_pkg::cfc_reg_req_t REG_REQ,
  output logic [15:0] RDATA,
  output cfc_pkg::cfc_state_t STATE,
  output logic DRV_EN,
  output logic FLAG_DOMINANT,
  output logic RETX_REQ
);

  typedef struct packed {
    logic rx_s1;
    logic rx_s2;
    logic enable;
    cfc_state_t fsm;
    logic [7:0] receive_fault_count;
    logic [8:0] transmit_fault_count;
    logic flag_hold;
    logic flag_dom;
    logic dom_arm;
    logic [3:0] dom_cnt;
    logic [3:0] dom_lim;
    logic [7:0] runs;
    logic drv_en;
    logic retx;
    logic [15:0] rdata;
  } cfc_core_t;

  cfc_core_t s;
  cfc_core_t next_s;
  logic run_done;
  logic run_clear;
  logic dom_hit_any;

  // counter step helper: add with saturation in the 9-bit range
  function automatic logic [8:0] cfc_add(input logic [8:0] v, input logic [4:0] amt);
    logic [9:0] sum;
    sum = {1'b0, v} + {5'h00, amt};
    cfc_add = sum[9] ? 9'h1FF : sum[8:0];
  endfunction : cfc_add

  // state chosen from counter values alone
  function automatic cfc_state_t cfc_level(input logic [8:0] tx, input logic [7:0] rx);
    logic [8:0] rx9;
    rx9 = {1'b0, rx};
    if (tx > `CFC_BUSOFF_LIMIT) begin
      cfc_level = ST_BUSOFF;
    end else if (tx > `CFC_PASSIVE_LIMIT || rx9 > `CFC_PASSIVE_LIMIT) begin
      cfc_level = ST_PASSIVE;
    end else if (tx >= `CFC_WARN_LIMIT || rx9 >= `CFC_WARN_LIMIT) begin
      cfc_level = ST_WARNING;
    end else begin
      cfc_level = ST_ACTIVE;
    end
  endfunction : cfc_level

  function automatic logic cfc_on_bus(input cfc_state_t st);
    cfc_on_bus = (st == ST_ACTIVE) || (st == ST_WARNING) || (st == ST_PASSIVE);
  endfunction : cfc_on_bus

  // recessive run detector shared by synchronisation and bus-off recovery
  cfc_run_counter u_run (
    .clk(CLK),
    .rst(RST),
    .clear(run_clear),
    .bit_tick(BIT_TICK),
    .bus_level(s.rx_s2),
    .run_done(run_done)
  );

  assign run_clear = !s.enable || WAKE;

  // all event handling, counters and state transitions
  always_comb begin
    logic [8:0] rx_add;
    logic [8:0] tx_add;
    logic dom_hit;
    logic on_bus;
    logic any_err;
    logic passive_now;
    logic [8:0] rec9;
    rx_add = 9'h000;
    tx_add = 9'h000;
    dom_hit = 1'b0;
    on_bus = cfc_on_bus(s.fsm);
    any_err = EVENTS.other_err || EVENTS.bit_err_flag;
    passive_now = (s.fsm == ST_PASSIVE);
    rec9 = {1'b0, s.receive_fault_count};
    next_s = s;
    next_s.rx_s1 = CAN_RX;
    next_s.rx_s2 = s.rx_s1;
    next_s.retx = 1'b0;

    // register writes: the control register steers the enable
    if (REG_REQ.wr && REG_REQ.addr == `CFC_OFS_CTRL) begin
      next_s.enable = REG_REQ.wdata[`CFC_CTRL_EN_BIT];
    end

    // dominant run after own flag, counted at sample points
    if (on_bus && EVENTS.flag_done) begin
      next_s.dom_arm = 1'b1;
      next_s.dom_cnt = 4'h0;
      next_s.dom_lim = EVENTS.flag_passive ? `CFC_DOM_FIRST_PASSIVE : `CFC_DOM_FIRST_ACTIVE;
    end else if (s.dom_arm && BIT_TICK) begin
      if (s.rx_s2) begin
        next_s.dom_arm = 1'b0;
      end else if (s.dom_cnt + 4'h1 == s.dom_lim) begin
        dom_hit = 1'b1;
        next_s.dom_cnt = 4'h0;
        next_s.dom_lim = `CFC_DOM_REPEAT;
      end else begin
        next_s.dom_cnt = s.dom_cnt + 4'h1;
      end
    end

    // increments; ignored off the bus
    if (on_bus) begin
      if (EVENTS.is_tx) begin
        if (EVENTS.bit_err_flag) begin
          tx_add = cfc_add(tx_add, `CFC_STEP_BIG);
        end
        if (EVENTS.other_err && !EVENTS.arb_stuff
            && !(EVENTS.ack_err && passive_now && !EVENTS.dom_in_pflag)) begin
          tx_add = cfc_add(tx_add, `CFC_STEP_BIG);
        end
        if (dom_hit) begin
          tx_add = cfc_add(tx_add, `CFC_STEP_BIG);
        end
        if (EVENTS.ack_err) begin
          next_s.retx = 1'b1;
        end
      end else begin
        if (EVENTS.bit_err_flag) begin
          rx_add = cfc_add(rx_add, `CFC_STEP_BIG);
        end
        if (EVENTS.dom_after_flag) begin
          rx_add = cfc_add(rx_add, `CFC_STEP_BIG);
        end
        if (EVENTS.other_err) begin
          rx_add = cfc_add(rx_add, `CFC_STEP_SMALL);
        end
        if (dom_hit) begin
          rx_add = cfc_add(rx_add, `CFC_STEP_BIG);
        end
      end
      // receive counter: frozen upward once bit 7 is set
      if (rx_add != 9'h000) begin
        if (!s.receive_fault_count[7]) begin
          next_s.receive_fault_count = 8'(cfc_add(rec9, rx_add[4:0]));
        end
      end else if (EVENTS.valid_rx && s.receive_fault_count != 8'h00) begin
        next_s.receive_fault_count = s.receive_fault_count - 8'h01;
      end
      // transmit counter keeps a ninth bit to see the bus-off crossing
      if (tx_add != 9'h000) begin
        next_s.transmit_fault_count = cfc_add(s.transmit_fault_count, tx_add[4:0]);
      end else if (EVENTS.valid_tx && s.transmit_fault_count != 9'h000) begin
        next_s.transmit_fault_count = s.transmit_fault_count - 9'h001;
      end
    end

    // flag polarity is fixed by the state before the error is counted
    if (on_bus && any_err) begin
      next_s.flag_hold = 1'b1;
      next_s.flag_dom = (s.fsm != ST_PASSIVE);
    end else if (EVENTS.flag_done) begin
      next_s.flag_hold = 1'b0;
    end

    // state transitions
    if (!s.enable) begin
      next_s.fsm = ST_SYNC;
      next_s.receive_fault_count = 8'h00;
      next_s.transmit_fault_count = 9'h000;
      next_s.runs = 8'h00;
      next_s.dom_arm = 1'b0;
      next_s.flag_hold = 1'b0;
    end else if (WAKE) begin
      next_s.fsm = ST_SYNC;
      next_s.dom_arm = 1'b0;
      next_s.flag_hold = 1'b0;
    end else begin
      unique case (s.fsm)
        ST_SYNC: begin
          if (run_done) begin
            next_s.fsm = ST_ACTIVE;
          end
        end
        ST_BUSOFF: begin
          next_s.dom_arm = 1'b0;
          next_s.flag_hold = 1'b0;
          if (run_done) begin
            if (s.runs == `CFC_BUSOFF_RUNS - 8'h01) begin
              next_s.fsm = ST_ACTIVE;
              next_s.receive_fault_count = 8'h00;
              next_s.transmit_fault_count = 9'h000;
              next_s.runs = 8'h00;
            end else begin
              next_s.runs = s.runs + 8'h01;
            end
          end
        end
        ST_ACTIVE, ST_WARNING, ST_PASSIVE: begin
          next_s.fsm = cfc_level(next_s.transmit_fault_count, next_s.receive_fault_count);
          next_s.runs = 8'h00;
        end
        default: begin
          next_s.fsm = ST_SYNC;
        end
      endcase
    end

    // drivers only while taking part in traffic
    next_s.drv_en = cfc_on_bus(next_s.fsm);
    if (!next_s.flag_hold) begin
      next_s.flag_dom = (next_s.fsm == ST_ACTIVE) || (next_s.fsm == ST_WARNING);
    end

    // read data stand in the cycle after the read strobe only
    next_s.rdata = 16'h0000;
    if (REG_REQ.rd) begin
      unique case (REG_REQ.addr)
        `CFC_OFS_PAIR: begin
          // counters past 255 show as ff; the node is bus off then
          next_s.rdata = {(s.transmit_fault_count[8] ? 8'hFF : s.transmit_fault_count[7:0]), s.receive_fault_count};
        end
        `CFC_OFS_CTRL: begin
          next_s.rdata = {15'h0000, s.enable};
        end
        `CFC_OFS_STAT: begin
          next_s.rdata = {13'h0000, s.fsm};
        end
        default: begin
          next_s.rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      s <= '0;
      s.rx_s1 <= 1'b1;
      s.rx_s2 <= 1'b1;
      s.enable <= 1'b0;
      s.fsm <= ST_SYNC;
    end else begin
      s <= next_s;
    end
  end

  assign RDATA = s.rdata;
  assign STATE = s.fsm;
  assign DRV_EN = s.drv_en;
  assign FLAG_DOMINANT = s.flag_dom;
  assign RETX_REQ = s.retx;

  // checks on the registered behaviour
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_sync_done;
    s.enable && !WAKE && s.fsm == ST_SYNC && run_done;
  endsequence

  property p_sync_exit;
    s_sync_done |=> s.fsm == ST_ACTIVE ##1 DRV_EN;
  endproperty
  a_sync_exit: assert property (p_sync_exit) else $error("sync did not end in active");

  property p_wake_sync;
    s.enable && WAKE |=> s.fsm == ST_SYNC && !DRV_EN;
  endproperty
  a_wake_sync: assert property (p_wake_sync) else $error("wake did not resync");

  property p_passive_level;
    s.enable && s.fsm == ST_PASSIVE |-> s.transmit_fault_count > 9'h07F || s.receive_fault_count > 8'h7F;
  endproperty
  a_passive_level: assert property (p_passive_level) else $error("passive below limit");

  property p_warn_level;
    s.fsm == ST_WARNING |-> (s.transmit_fault_count >= 9'h060 || s.receive_fault_count >= 8'h60) && s.transmit_fault_count < 9'h080
      && s.receive_fault_count < 8'h80;
  endproperty
  a_warn_level: assert property (p_warn_level) else $error("warning outside 96..127");

  property p_busoff_drv;
    s.fsm == ST_BUSOFF |=> !DRV_EN || s.fsm != ST_BUSOFF;
  endproperty
  a_busoff_drv: assert property (p_busoff_drv) else $error("drivers on in bus off");

  property p_busoff_entry;
    s.enable && !WAKE && cfc_on_bus(s.fsm) && next_s.transmit_fault_count > 9'h0FF |=> s.fsm == ST_BUSOFF;
  endproperty
  a_busoff_entry: assert property (p_busoff_entry) else $error("missed bus off");

  property p_recovery_clear;
    s.fsm == ST_BUSOFF ##1 s.fsm == ST_ACTIVE |-> s.transmit_fault_count == 9'h000 && s.receive_fault_count == 8'h00;
  endproperty
  a_recovery_clear: assert property (p_recovery_clear) else $error("counters not cleared");

  property p_rec_frozen;
    s.enable && !WAKE && s.receive_fault_count[7] && cfc_on_bus(s.fsm) |=> s.receive_fault_count <= $past(s.receive_fault_count);
  endproperty
  a_rec_frozen: assert property (p_rec_frozen) else $error("rec rose past bit 7");

  property p_arb_stuff;
    s.enable && !WAKE && cfc_on_bus(s.fsm) && EVENTS.is_tx && EVENTS.other_err
      && EVENTS.arb_stuff && !EVENTS.bit_err_flag && !dom_hit_any |=> s.transmit_fault_count <= $past(s.transmit_fault_count);
  endproperty
  a_arb_stuff: assert property (p_arb_stuff) else $error("tec rose on arbitration stuff");

  property p_passive_flag;
    s.fsm == ST_PASSIVE && !s.flag_hold |-> !FLAG_DOMINANT;
  endproperty
  a_passive_flag: assert property (p_passive_flag) else $error("dominant flag when passive");

  property p_ack_retx;
    s.enable && !WAKE && cfc_on_bus(s.fsm) && EVENTS.is_tx && EVENTS.ack_err |=> RETX_REQ;
  endproperty
  a_ack_retx: assert property (p_ack_retx) else $error("no retransmit on ack error");

  // helper for the arbitration check: a dominant-run step may coincide
  assign dom_hit_any = s.dom_arm && BIT_TICK && !s.rx_s2;

endmodule : cfc_fault_confinement

// [verif/cfc_bus_nodes.sv]
/*
  the other can nodes on the shared bus: bit sample ticks and wired level.
  assumes the bench raises dom while some other node drives dominant.
*/
`timescale 1ns/1ns

module cfc_bus_nodes (
  input wire logic clk,
  input wire logic rst,
  input wire logic dom,
  output logic can_rx,
  output logic bit_tick
);
  logic [1:0] div;

  // one sample point every four clocks keeps long runs short
  always_ff @(posedge clk) begin
    if (rst) begin
      div <= 2'h0;
    end else begin
      div <= div + 2'h1;
    end
  end

  // wired-and bus: idle and released lines read recessive
  assign bit_tick = (div == 2'h3);
  assign can_rx = ~dom;
endmodule : cfc_bus_nodes

// [verif/testbench.sv]
/*
  self-checking bench for the fault confinement block.
  assumes the bus model in cfc_bus_nodes.sv and the register map constants.
*/
`timescale 1ns/1ns
`include "cfc_defines.svh"

module testbench;
  import cfc_pkg::*;
  localparam logic [10:0] E_TX = 11'h400, E_BIT = 11'h200, E_DAF = 11'h100;
  localparam logic [10:0] E_OTH = 11'h080, E_ARB = 11'h040, E_ACK = 11'h020;
  localparam logic [10:0] E_DPF = 11'h010, E_FD = 11'h008, E_FP = 11'h004;
  localparam logic [10:0] E_VRX = 11'h002, E_VTX = 11'h001;
  logic clk, rst, wake, dom, can_rx, bit_tick, drv_en, flag_dom, retx;
  cfc_event_t ev;
  cfc_reg_req_t req;
  cfc_state_t state;
  logic [15:0] rdata;
  logic [15:0] got;
  int err_count, n_compared, transmit_fault_count, receive_fault_count;

  cfc_fault_confinement u_dut (.CLK(clk), .RST(rst), .CAN_RX(can_rx), .BIT_TICK(bit_tick),
    .WAKE(wake), .EVENTS(ev), .REG_REQ(req), .RDATA(rdata), .STATE(state),
    .DRV_EN(drv_en), .FLAG_DOMINANT(flag_dom), .RETX_REQ(retx));
  cfc_bus_nodes u_bus (.clk(clk), .rst(rst), .dom(dom), .can_rx(can_rx),
    .bit_tick(bit_tick));

  // 50 mhz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // state the counters should put the node in
  function automatic cfc_state_t exp_st();
    if (transmit_fault_count > 255) return ST_BUSOFF;
    if (transmit_fault_count > 127 || receive_fault_count > 127) return ST_PASSIVE;
    if (transmit_fault_count >= 96 || receive_fault_count >= 96) return ST_WARNING;
    return ST_ACTIVE;
  endfunction : exp_st

  function automatic logic [15:0] exp_pair();
    logic [7:0] t;
    t = (transmit_fault_count > 255) ? 8'hFF : 8'(transmit_fault_count);
    return {t, 8'(receive_fault_count)};
  endfunction : exp_pair

  // register port: one-cycle strobes, read data in the cycle after
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 got = rdata;
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic chk_pair();
    rd(`CFC_OFS_PAIR);
    chk(got, exp_pair());
  endtask : chk_pair

  task automatic pulse(input logic [10:0] e);
    @(posedge clk);
    ev <= cfc_event_t'(e);
    @(posedge clk);
    ev <= '0;
    #1;
  endtask : pulse

  // one event, counter model updated, state compared
  task automatic step(input logic [10:0] e, input int dt, input int dr);
    pulse(e);
    transmit_fault_count = (transmit_fault_count + dt < 0) ? 0 : transmit_fault_count + dt;
    if (receive_fault_count < 128 || dr < 0) receive_fault_count = (receive_fault_count + dr < 0) ? 0 : receive_fault_count + dr;
    chk(16'(state), 16'(exp_st()));
  endtask : step

  task automatic wait_st(input cfc_state_t s, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      if (state === s) break;
    end
    chk(16'(state), 16'(s));
  endtask : wait_st

  // dominant run after own flag; reads fit between two ticks
  task automatic drun(input logic [10:0] e, input int first);
    @(posedge clk);
    dom <= 1'b1;
    @(posedge bit_tick);
    pulse(e);
    repeat (first - 1) @(posedge bit_tick);
    @(posedge clk);
    chk_pair();
    @(posedge bit_tick);
    @(posedge clk);
    receive_fault_count += 8;
    chk_pair();
    repeat (8) @(posedge bit_tick);
    @(posedge clk);
    receive_fault_count += 8;
    chk_pair();
    dom <= 1'b0;
  endtask : drun

  // watchdog, well beyond the expected run of under 10000 cycles
  initial begin
    #400000;
    err_count++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    wake = 1'b0;
    dom = 1'b1;
    ev = '0;
    req = '0;
    transmit_fault_count = 0;
    receive_fault_count = 0;
    err_count = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(`CFC_OFS_CTRL);
    chk(got, `CFC_CTRL_RESET);
    rd(4'hC);
    chk(got, 16'h0000);
    @(posedge clk);
    #1 chk(rdata, 16'h0000);
    wr(`CFC_OFS_PAIR, 16'hFFFF);
    chk_pair();
    wr(`CFC_OFS_CTRL, 16'h0001);
    repeat (80) @(posedge clk);
    #1 chk(16'(state), 16'(ST_SYNC));
    dom <= 1'b0;
    repeat (36) @(posedge clk);
    #1 chk(16'(state), 16'(ST_SYNC));
    wait_st(ST_ACTIVE, 30);
    chk(drv_en, 16'h0001);
    chk(flag_dom, 16'h0001);
    step(E_OTH, 0, 1);
    chk_pair();
    step(E_VRX, 0, -1);
    step(E_VRX, 0, -1);
    chk_pair();
    step(E_TX | E_OTH | E_ARB, 0, 0);
    step(E_VTX, -1, 0);
    chk_pair();
    repeat (12) step(E_TX | E_OTH, 8, 0);
    chk_pair();
    step(E_VTX, -1, 0);
    repeat (4) step(E_TX | E_OTH, 8, 0);
    step(E_TX | E_OTH, 8, 0);
    chk(flag_dom, 16'h0001);
    pulse(E_FD);
    chk(flag_dom, 16'h0000);
    pulse(E_TX | E_OTH | E_ACK);
    chk(retx, 16'h0001);
    chk_pair();
    step(E_TX | E_OTH | E_ACK | E_DPF, 8, 0);
    chk_pair();
    repeat (16) step(E_VTX, -1, 0);
    step(E_BIT, 0, 8);
    step(E_DAF, 0, 8);
    chk_pair();
    drun(E_FD, 14);
    drun(E_FD | E_FP, 8);
    repeat (10) step(E_BIT, 0, 8);
    step(E_OTH, 0, 1);
    chk_pair();
    step(E_VRX, 0, -1);
    repeat (17) step(E_TX | E_OTH, 8, 0);
    chk_pair();
    chk(drv_en, 16'h0000);
    rd(`CFC_OFS_STAT);
    chk(got, 16'(ST_BUSOFF));
    pulse(E_OTH);
    chk_pair();
    repeat (1300) @(posedge bit_tick);
    #1 chk(16'(state), 16'(ST_BUSOFF));
    wait_st(ST_ACTIVE, 600);
    transmit_fault_count = 0;
    receive_fault_count = 0;
    chk_pair();
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    #1 chk(16'(state), 16'(ST_SYNC));
    wait_st(ST_ACTIVE, 70);
    step(E_TX | E_BIT, 8, 0);
    chk_pair();
    wr(`CFC_OFS_CTRL, 16'h0000);
    transmit_fault_count = 0;
    receive_fault_count = 0;
    @(posedge clk);
    #1 chk(16'(state), 16'(ST_SYNC));
    chk_pair();
    summarize();
  end
endmodule : testbench
